// File: core/smbl_pkg.sv
package smbl_pkg;
  // Clock and serial rates
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned EEPROM_MAX_BPS = 4_000_000;
  localparam int unsigned FLASH_MAX_BPS  = 10_000_000;
  // Half period of the serial clock, least time so rounded up
  localparam int unsigned EEPROM_HALF    = (CLK_HZ + 2 * EEPROM_MAX_BPS - 1) / (2 * EEPROM_MAX_BPS);
  localparam int unsigned FLASH_HALF     = (CLK_HZ + 2 * FLASH_MAX_BPS - 1) / (2 * FLASH_MAX_BPS);
  localparam logic [7:0]  EEPROM_HALF_C  = 8'(EEPROM_HALF);
  localparam logic [7:0]  FLASH_HALF_C   = 8'(FLASH_HALF);
  localparam logic [7:0]  CS_GAP_CYCLES  = 8'h10;

  // Serial memory commands and identification replies
  localparam logic [7:0]  CMD_READ_IDENTIFICATION_CMD    = 8'h9F;
  localparam logic [7:0]  CMD_READ       = 8'h03;
  localparam logic [7:0]  ID_ALL_ZERO    = 8'h00;
  localparam logic [7:0]  ID_ALL_ONE     = 8'hFF;
  localparam logic [1:0]  EEPROM_ADDR_B  = 2'h2;
  localparam logic [1:0]  FLASH_ADDR_B   = 2'h3;

  // Boot-mode codes
  localparam logic [3:0]  BOOT_ALT_SPI   = 4'hC;
  localparam logic [3:0]  BOOT_MAIN_LO   = 4'h8;
  localparam logic [3:0]  BOOT_MAIN_HI   = 4'hB;

  // Register byte offsets
  localparam logic [11:0] REG_CTRL       = 12'h000;
  localparam logic [11:0] REG_STATUS     = 12'h004;
  localparam logic [11:0] REG_IRQ_STAT   = 12'h008;
  localparam logic [11:0] REG_IRQ_MASK   = 12'h00C;
  localparam logic [11:0] MEM_BASE       = 12'h400;

  // Field positions
  localparam int unsigned CTRL_PLL_EN    = 0;
  localparam int unsigned IRQ_DONE       = 0;
  localparam int unsigned IRQ_ERR        = 1;
  localparam int unsigned IRQ_W          = 2;

  // Reset values
  localparam logic [31:0] DATA_ZERO      = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_RST   = 2'h0;

  // Loader sequencer states
  typedef enum logic [3:0] {
    ST_WAIT    = 4'h0,
    ST_DECIDE  = 4'h1,
    ST_ID_CMD  = 4'h2,
    ST_ID_RD   = 4'h3,
    ST_GAP     = 4'h4,
    ST_RD_CMD  = 4'h5,
    ST_RD_ADDR = 4'h6,
    ST_RD_DATA = 4'h7,
    ST_DONE    = 4'h8,
    ST_ERROR   = 4'h9,
    ST_OTHER   = 4'hA
  } smbl_state_t;
endpackage

// File: core/smbl_spi_if.sv
`timescale 1ns/10ps
// Byte-transfer handshake between sequencer and shifter
interface smbl_spi_if;
  logic       start;   // One-cycle request for one byte
  logic [7:0] tx;      // Byte to send
  logic [7:0] half;    // Serial clock half period in cycles
  logic [7:0] rx;      // Byte received
  logic       done;    // One-cycle pulse, rx valid
  modport ctrl  (output start, output tx, output half, input rx, input done);
  modport shift (input start, input tx, input half, output rx, output done);
endinterface

// File: core/smbl_image_ram.sv
`timescale 1ns/10ps
// Simple dual-port store for the downloaded image
module smbl_image_ram #(
  parameter int unsigned AW = 8,
  parameter int unsigned DW = 8
) (
  // Clock
  input  wire logic          clk_i,
  input  wire logic          ce_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  // Read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];  // Image bytes

  // Write and registered read
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

// File: core/smbl_spi_shifter.sv
`timescale 1ns/10ps
// Mode 0 serial master: clock idles low, sample at end of high phase
module smbl_spi_shifter
  import smbl_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // Byte handshake
  smbl_spi_if.shift bus,
  // Serial lines
  input  wire logic miso_i,   // Already synchronised
  output logic      sck_o,
  output logic      mosi_o
);
  logic [7:0] sh_q;     // Shift register, MSB first
  logic [7:0] cnt_q;    // Half-period counter
  logic [2:0] bits_q;   // Bits done in this byte
  logic       busy_q;   // Byte in flight
  logic       done_q;   // Completion pulse

  wire half_end = (cnt_q == 8'h01);
  wire last_bit = (bits_q == 3'h7);

  assign mosi_o   = sh_q[7];
  assign bus.rx   = sh_q;
  assign bus.done = done_q;

  // Sampling late in the high phase leaves room for the input synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_q   <= 8'h00;
      cnt_q  <= 8'h00;
      bits_q <= 3'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      sck_o  <= 1'b0;
    end else if (ce_i) begin
      done_q <= 1'b0;
      if (!busy_q) begin
        if (bus.start) begin
          sh_q   <= bus.tx;
          cnt_q  <= bus.half;
          bits_q <= 3'h0;
          busy_q <= 1'b1;
        end
      end else if (!half_end) begin
        cnt_q <= cnt_q - 8'h01;
      end else begin
        cnt_q <= bus.half;
        sck_o <= !sck_o;
        if (sck_o) begin
          // Falling edge: take the bit, present the next one
          sh_q   <= {sh_q[6:0], miso_i};
          bits_q <= bits_q + 3'h1;
          if (last_bit) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// File: core/smbl_loader.sv
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module smbl_loader
  import smbl_pkg::*;
#(
  parameter int unsigned IMG_AW  = 8,      // Image holds 2**IMG_AW bytes
  parameter logic [7:0]  MAGIC   = 8'hA5   // Expected first image byte
) (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Power-on reset pin and straps
  input  wire logic        power_on_reset_input_n_i,
  input  wire logic [3:0]  boot_mode_straps_i,
  input  wire logic        watchdog_config_strap_i,
  input  wire logic        host_request_line_i,
  input  wire logic        host_transmit_request_line_i,
  // Main pin set
  output logic             boot_mode_strap_two_o,
  output logic             boot_mode_strap_two_oe_o,
  output logic             host_addr_line_three_o,
  output logic             host_addr_line_three_oe_o,
  output logic             host_chip_select_two_o,
  output logic             host_chip_select_two_oe_o,
  // Alternate pin set
  output logic             uart_transmit_pin_o,
  output logic             uart_transmit_pin_oe_o,
  input  wire logic        uart_receive_pin_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Status outputs
  output logic             event_output_three_o,
  output logic             pll_bypass_o,
  output logic             watchdog_cfg_o,
  output logic [1:0]       parallel_host_port_mode_o,
  output logic             irq_o
);
  // Pin synchronisers: straps, power-on reset, both data-in pins
  logic [9:0] sync1_q;  // First stage, read only by second
  logic [9:0] sync2_q;  // Second stage, usable
  logic       por_d1_q; // Delayed second stage for edge detection

  // Latched configuration
  logic [3:0] code_q;       // Boot-mode straps
  logic       wd_q;         // Watchdog strap
  logic [1:0] hmode_q;      // Parallel host port mode
  logic       latched_q;    // Straps taken
  logic       alt_q;        // Alternate pin set in use
  logic       spi_on_q;     // Serial boot pins driven
  logic       eeprom_q;     // EEPROM access routines

  // Sequencer
  smbl_state_t st_q;
  logic        wait_q;      // Byte requested, awaiting done
  logic [1:0]  ab_q;        // Address bytes left
  logic [7:0]  gap_q;       // Select-high gap counter
  logic [IMG_AW-1:0] idx_q; // Image byte index
  logic        err_q;       // Sticky failure

  // Registers
  logic               pll_en_q;
  logic [IRQ_W-1:0]   ist_q;
  logic [IRQ_W-1:0]   imask_q;
  logic               pend_q;

  smbl_spi_if spi ();
  logic sck;
  logic mosi;
  logic [7:0] ram_rd;

  // Decode of the synchronised pins
  wire        por_n   = sync2_q[5];
  wire        por_on  = !por_n;
  wire        por_rel = por_n && !por_d1_q;
  wire        miso    = alt_q ? sync2_q[9] : sync2_q[8];
  wire        is_alt  = (code_q == BOOT_ALT_SPI);
  wire        is_main = (code_q >= BOOT_MAIN_LO) && (code_q <= BOOT_MAIN_HI);
  wire        id_ee   = (spi.rx == ID_ALL_ZERO) || (spi.rx == ID_ALL_ONE);
  wire        cs_low  = spi_on_q && (st_q inside {ST_ID_CMD, ST_ID_RD, ST_RD_CMD, ST_RD_ADDR, ST_RD_DATA});
  wire        img_end = (idx_q == {IMG_AW{1'b1}});
  wire        ram_we  = spi.done && (st_q == ST_RD_DATA);

  // Bus decode
  wire        req     = wb_cyc_i && wb_stb_i && !pend_q && !wb_ack_o;
  wire        wr      = pend_q && wb_we_i;
  wire        sel_lo  = wb_sel_i[0];
  wire        hit_mem = (wb_adr_i >= MEM_BASE);
  wire [31:0] status  = {16'h0000, 2'h0, hmode_q, code_q, wd_q, alt_q, eeprom_q, pll_bypass_o,
                         latched_q, err_q, st_q == ST_DONE, spi_on_q};
  wire [31:0] rd_mux  = hit_mem                   ? {24'h000000, ram_rd} :
                        (wb_adr_i == REG_CTRL)    ? {31'h0, pll_en_q} :
                        (wb_adr_i == REG_STATUS)  ? status :
                        (wb_adr_i == REG_IRQ_STAT)? {30'h0, ist_q} :
                        (wb_adr_i == REG_IRQ_MASK)? {30'h0, imask_q} : DATA_ZERO;
  wire [IRQ_W-1:0] ev = {ram_we && idx_q == '0 && spi.rx != MAGIC,  // Bad first byte: error
                         ram_we && img_end};                        // Last byte stored: done

  // Byte engine
  smbl_spi_shifter u_shift (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .bus    (spi.shift),
    .miso_i (miso),
    .sck_o  (sck),
    .mosi_o (mosi)
  );

  // Image store, read by software after the download
  smbl_image_ram #(.AW(IMG_AW), .DW(8)) u_ram (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (ram_we),
    .waddr_i (idx_q),
    .wdata_i (spi.rx),
    .raddr_i (wb_adr_i[IMG_AW+1:2]),
    .rdata_o (ram_rd)
  );

  assign spi.half = eeprom_q ? EEPROM_HALF_C : FLASH_HALF_C;

  // Main set carries the traffic on upper strap, address three, select two
  assign boot_mode_strap_two_o     = mosi;
  assign host_addr_line_three_o    = sck;
  assign host_chip_select_two_o    = !cs_low;
  assign boot_mode_strap_two_oe_o  = spi_on_q && !alt_q;
  assign host_addr_line_three_oe_o = spi_on_q && !alt_q;
  assign host_chip_select_two_oe_o = spi_on_q && !alt_q;
  // Alternate set: transmit carries data out, SCL the clock, SDA the select
  assign uart_transmit_pin_o       = mosi;
  assign scl_o                     = sck;
  assign sda_o                     = !cs_low;
  assign uart_transmit_pin_oe_o    = spi_on_q && alt_q;
  assign scl_oe_o                  = spi_on_q && alt_q;
  assign sda_oe_o                  = spi_on_q && alt_q;

  assign event_output_three_o      = err_q;
  assign pll_bypass_o              = !(pll_en_q && !alt_q);
  assign watchdog_cfg_o            = wd_q;
  assign parallel_host_port_mode_o = hmode_q;
  assign irq_o                     = |(ist_q & imask_q);

  // Two-stage synchronisers for every pin the loader looks at
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q  <= 10'h000;
      sync2_q  <= 10'h000;
      por_d1_q <= 1'b0;
    end else if (ce_i) begin
      sync1_q  <= {uart_receive_pin_i, boot_mode_straps_i[3], host_transmit_request_line_i,
                   host_request_line_i, power_on_reset_input_n_i, watchdog_config_strap_i,
                   boot_mode_straps_i};
      sync2_q  <= sync1_q;
      por_d1_q <= sync2_q[5];
    end
  end

  // Mode straps follow the pins while power-on reset is held, watchdog strap taken at release; all then freeze
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_q    <= 4'h0;
      wd_q      <= 1'b0;
      hmode_q   <= 2'h0;
      latched_q <= 1'b0;
    end else if (ce_i) begin
      if (por_on) begin
        code_q    <= sync2_q[3:0];
        hmode_q   <= sync2_q[7:6];
        latched_q <= 1'b0;
      end else if (por_rel && !latched_q) begin
        wd_q      <= sync2_q[4];
        latched_q <= 1'b1;
      end
    end
  end

  // Sequencer: identify the memory, then download the image
  always_ff @(posedge clk_i) begin
    if (rst_i || por_on) begin
      st_q      <= ST_WAIT;
      wait_q    <= 1'b0;
      spi.start <= 1'b0;
      spi.tx    <= 8'h00;
      ab_q      <= 2'h0;
      gap_q     <= 8'h00;
      idx_q     <= '0;
      err_q     <= 1'b0;
      alt_q     <= 1'b0;
      spi_on_q  <= 1'b0;
      eeprom_q  <= 1'b1;
    end else if (ce_i) begin
      spi.start <= 1'b0;
      case (st_q)
        ST_WAIT: begin
          if (latched_q) begin
            st_q <= ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          // Serial boot only for its own codes; other ports are not this loader's job
          alt_q    <= is_alt;
          spi_on_q <= is_alt || is_main;
          st_q     <= (is_alt || is_main) ? ST_ID_CMD : ST_OTHER;
        end
        ST_ID_CMD, ST_RD_CMD: begin
          if (!wait_q) begin
            spi.tx    <= (st_q == ST_ID_CMD) ? CMD_READ_IDENTIFICATION_CMD : CMD_READ;
            spi.start <= 1'b1;
            wait_q    <= 1'b1;
          end else if (spi.done) begin
            wait_q <= 1'b0;
            ab_q   <= eeprom_q ? EEPROM_ADDR_B : FLASH_ADDR_B;
            st_q   <= (st_q == ST_ID_CMD) ? ST_ID_RD : ST_RD_ADDR;
          end
        end
        ST_ID_RD, ST_RD_DATA: begin
          if (!wait_q) begin
            spi.tx    <= 8'h00;
            spi.start <= 1'b1;
            wait_q    <= 1'b1;
          end else if (spi.done) begin
            wait_q <= 1'b0;
            if (st_q == ST_ID_RD) begin
              eeprom_q <= id_ee;
              gap_q    <= CS_GAP_CYCLES;
              st_q     <= ST_GAP;
            end else if (idx_q == '0 && spi.rx != MAGIC) begin
              err_q <= 1'b1;
              st_q  <= ST_ERROR;
            end else begin
              idx_q <= idx_q + 1'b1;
              st_q  <= img_end ? ST_DONE : ST_RD_DATA;
            end
          end
        end
        ST_GAP: begin
          // Select stays high a while so the memory sees a new command
          gap_q <= gap_q - 8'h01;
          if (gap_q == 8'h01) begin
            st_q <= ST_RD_CMD;
          end
        end
        ST_RD_ADDR: begin
          if (!wait_q) begin
            spi.tx    <= 8'h00;                             // Image starts at address zero
            spi.start <= 1'b1;
            wait_q    <= 1'b1;
          end else if (spi.done) begin
            wait_q <= 1'b0;
            ab_q   <= ab_q - 2'h1;
            if (ab_q == 2'h1) begin
              st_q <= ST_RD_DATA;
            end
          end
        end
        ST_DONE: begin
          spi_on_q <= 1'b0;                                 // Release shared pins
        end
        ST_ERROR: begin
          spi_on_q <= 1'b0;
        end
        ST_OTHER: begin
          spi_on_q <= 1'b0;
        end
        default: begin
          st_q <= ST_WAIT;
        end
      endcase
    end
  end

  // Bus slave: request takes one cycle to reach memory, answer the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q   <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= DATA_ZERO;
    end else if (ce_i) begin
      pend_q   <= req;
      wb_ack_o <= pend_q;
      if (pend_q) begin
        wb_dat_o <= wb_we_i ? DATA_ZERO : rd_mux;
      end
    end
  end

  // Control, mask and interrupt status; a new event wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_en_q <= 1'b0;
      imask_q  <= IRQ_RST;
      ist_q    <= IRQ_RST;
    end else if (ce_i) begin
      if (por_on) begin
        pll_en_q <= 1'b0;
      end else if (wr && sel_lo && wb_adr_i == REG_CTRL) begin
        pll_en_q <= wb_dat_i[CTRL_PLL_EN];
      end
      if (wr && sel_lo && wb_adr_i == REG_IRQ_MASK) begin
        imask_q <= wb_dat_i[IRQ_W-1:0];
      end
      ist_q <= (ist_q & ~((wr && sel_lo && wb_adr_i == REG_IRQ_STAT) ? wb_dat_i[IRQ_W-1:0] : IRQ_RST)) | ev;
    end
  end
endmodule

// File: verification/smbl_asserts.sv
`timescale 1ns/10ps
// Pin-level checks for the serial boot loader
module smbl_asserts
  import smbl_pkg::*;
(
  // Clock, reset, power-on pin
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       power_on_reset_input_n_i,
  // Main set clock and select
  input wire logic       host_addr_line_three_o,
  input wire logic       host_addr_line_three_oe_o,
  input wire logic       host_chip_select_two_o,
  input wire logic       host_chip_select_two_oe_o,
  // Alternate set clock and select
  input wire logic       scl_o,
  input wire logic       scl_oe_o,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  // Status outputs
  input wire logic       event_output_three_o,
  input wire logic       pll_bypass_o,
  input wire logic       watchdog_cfg_o,
  input wire logic [1:0] parallel_host_port_mode_o,
  input wire logic       irq_o
);
  wire        main_on = host_addr_line_three_oe_o | host_chip_select_two_oe_o;  // Main set driven
  wire        alt_on  = scl_oe_o | sda_oe_o;                                    // Alternate set driven
  wire        sck_on  = (host_addr_line_three_oe_o & host_addr_line_three_o) | (scl_oe_o & scl_o);
  logic [7:0] hi_q;   // Cycles the serial clock has stayed high
  logic [2:0] por_q;  // High samples of the power-on pin, saturating

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // High-phase length, cleared when the clock falls
  always_ff @(posedge clk_i) begin
    if (rst_i) hi_q <= 8'h00;
    else hi_q <= sck_on ? hi_q + 8'h01 : 8'h00;
  end

  // Counts past the synchroniser delay so the capture edge is behind us
  always_ff @(posedge clk_i) begin
    if (rst_i || !power_on_reset_input_n_i) por_q <= 3'h0;
    else if (por_q != 3'h7) por_q <= por_q + 3'h1;
  end

  chk_one_pin_set: assert property (!(main_on && alt_on))
    else $error("both pin sets driven at once");
  chk_alt_no_pll: assert property (alt_on |-> pll_bypass_o)
    else $error("pll in use on alternate set");
  chk_main_sck_idle: assert property (
    host_chip_select_two_oe_o && host_chip_select_two_o |-> !host_addr_line_three_o)
    else $error("main clock high while deselected");
  chk_alt_sck_idle: assert property (sda_oe_o && sda_o |-> !scl_o)
    else $error("alternate clock high while deselected");
  chk_half_period: assert property (
    $fell(sck_on) |-> hi_q == EEPROM_HALF_C || hi_q == FLASH_HALF_C)
    else $error("serial clock high phase of wrong length");
  chk_err_released: assert property (
    event_output_three_o && $past(event_output_three_o, 2) |-> !main_on && !alt_on)
    else $error("pins still driven after failure");
  chk_err_sticky: assert property (
    event_output_three_o && power_on_reset_input_n_i && por_q >= 3'h3 |=> event_output_three_o)
    else $error("failure flag dropped without reset");
  chk_straps_frozen: assert property (
    por_q >= 3'h5 |-> $stable(watchdog_cfg_o) && $stable(parallel_host_port_mode_o))
    else $error("captured strap moved after release");
  chk_reset_bypass: assert property (
    $fell(rst_i) |-> pll_bypass_o && !event_output_three_o && !irq_o)
    else $error("bad output level after reset");
endmodule

// File: verification/smbl_mem_model.sv
`timescale 1ns/10ps
// Serial EEPROM or Flash; address length follows the identification byte
module smbl_mem_model
  import smbl_pkg::*;
(
  // Serial lines from the loader
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       mosi_i,
  // Identification reply and first image byte
  input  wire logic [7:0] id_i,
  input  wire logic [7:0] first_i,
  // Reply line
  output logic            miso_o
);
  logic [7:0] cmd;   // Command byte shifted in
  logic [7:0] b;     // Byte being sent
  int         nbit;  // Rising clocks in this frame
  int         idx;   // Reply byte index

  initial miso_o = 1'b0;
  // New frame; a released line shows no stale level
  always @(cs_n_i) begin
    nbit = 0;
    miso_o = ~miso_o;
  end
  // Shift in on the rising clock
  always @(posedge sck_i) begin
    if (!cs_n_i && nbit < 8) cmd = {cmd[6:0], mosi_i};
    if (!cs_n_i) nbit++;
  end
  // Next bit only after the falling clock, never in the high phase
  always @(negedge sck_i) begin
    idx = nbit / 8 - 1;
    if (cmd == CMD_READ) idx -= (id_i == ID_ALL_ZERO || id_i == ID_ALL_ONE) ? 2 : 3;
    if (cs_n_i || nbit < 8) b = {8{~miso_o}};
    else if (cmd == CMD_READ_IDENTIFICATION_CMD && idx == 0) b = id_i;
    else if (cmd == CMD_READ && idx >= 0) b = (idx == 0) ? first_i : 8'(idx) ^ 8'h3C;
    else b = {8{~miso_o}};  // Not driving: toggle
    miso_o = b[7 - nbit % 8];
  end
endmodule

// File: verification/tb_serial_memory_boot_loader.sv
`timescale 1ns/10ps
// Boots over both pin sets, checks status, image, interrupt and pll control
module tb_serial_memory_boot_loader;
  import smbl_pkg::*;
  localparam logic [7:0] MAGIC_V = 8'hA5;  // First image byte the loader accepts
  logic        clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i, boot_mode_straps_i, strap;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic        power_on_reset_input_n_i, watchdog_config_strap_i, host_request_line_i;
  logic        host_transmit_request_line_i, uart_receive_pin_i, miso, alt, rel, sck_q;
  logic        boot_mode_strap_two_o, boot_mode_strap_two_oe_o, host_addr_line_three_o;
  logic        host_addr_line_three_oe_o, host_chip_select_two_o, host_chip_select_two_oe_o;
  logic        uart_transmit_pin_o, uart_transmit_pin_oe_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
  logic        event_output_three_o, pll_bypass_o, watchdog_cfg_o, irq_o;
  logic [1:0]  parallel_host_port_mode_o;
  logic [7:0]  id, first;
  int          n_fail, tests_run, cyc_n, min_half, hc, main_seen, alt_seen, post_err;
  // Memory sees only the selected set; undriven select reads high
  wire sck_w  = alt ? scl_oe_o & scl_o : host_addr_line_three_oe_o & host_addr_line_three_o;
  wire cs_w   = alt ? ~sda_oe_o | sda_o : ~host_chip_select_two_oe_o | host_chip_select_two_o;
  wire mosi_w = alt ? uart_transmit_pin_o : boot_mode_strap_two_o;
  assign boot_mode_straps_i = rel ? {miso, strap[2:0]} : strap;
  assign uart_receive_pin_i = miso;

  smbl_loader #(.IMG_AW(4), .MAGIC(MAGIC_V)) uut (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .power_on_reset_input_n_i, .boot_mode_straps_i, .watchdog_config_strap_i,
    .host_request_line_i, .host_transmit_request_line_i, .boot_mode_strap_two_o, .boot_mode_strap_two_oe_o,
    .host_addr_line_three_o, .host_addr_line_three_oe_o, .host_chip_select_two_o, .host_chip_select_two_oe_o,
    .uart_transmit_pin_o, .uart_transmit_pin_oe_o, .uart_receive_pin_i, .scl_o, .scl_oe_o, .sda_o,
    .sda_oe_o, .event_output_three_o, .pll_bypass_o, .watchdog_cfg_o, .parallel_host_port_mode_o, .irq_o);
  smbl_mem_model mem (.sck_i(sck_w), .cs_n_i(cs_w), .mosi_i(mosi_w), .id_i(id), .first_i(first), .miso_o(miso));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Serial clock high-phase length, set use, clocks after a failure
  always @(posedge clk_i) begin
    sck_q <= sck_w;
    if (sck_w) hc <= hc + 1;
    else if (hc != 0) begin
      if (hc < min_half) min_half <= hc;
      hc <= 0;
    end
    if (host_addr_line_three_oe_o | host_chip_select_two_oe_o) main_seen <= 1;
    if (scl_oe_o | sda_oe_o) alt_seen <= 1;
    if (event_output_three_o && sck_w && !sck_q) post_err <= post_err + 1;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic bus cycle; waits for ack, a bounded wait
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    if (wb_ack_o !== 1'b1) n_fail++;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask

  // Strap a code, pulse power-on, let the boot finish, then check it
  task automatic run(input logic [3:0] c, input logic [7:0] i, f, input logic a, h, t, w);
    logic ser, err, ee;
    int k;
    ser = c inside {[4'h8:4'hC]};
    err = ser && f != MAGIC_V;
    ee = !ser || i == 8'h00 || i == 8'hFF;  // Idle loader keeps its slow reset speed
    {alt, rel, host_request_line_i, host_transmit_request_line_i, watchdog_config_strap_i} <= {a, 1'b0, h, t, w};
    {strap, id, first} <= {c, i, f};
    {min_half, main_seen, alt_seen, post_err} <= {32'd255, 96'd0};
    power_on_reset_input_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    power_on_reset_input_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    {rel, strap, watchdog_config_strap_i} <= {1'b1, ~c, ~w};
    k = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0);
      k++;
    end while (ser && rdat[2:1] === 2'b00 && k < 3000);
    repeat (4) @(posedge clk_i);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status", rdat, {18'h0, t, h, c, w, a, ee, 2'b11, err, ser && !err, 1'b0});
    chk("event pin", event_output_three_o, err);
    chk("host mode", parallel_host_port_mode_o, {t, h});
    chk("watchdog", watchdog_cfg_o, w);
    chk("half period", min_half, ser ? (ee ? EEPROM_HALF : FLASH_HALF) : 255);
    chk("main set used", main_seen, ser && !a);
    chk("alt set used", alt_seen, ser && a);
    chk("clocks after error", post_err, 0);
    wb(1'b1, REG_IRQ_MASK, 32'h0);
    wb(1'b0, REG_IRQ_STAT, 32'h0);
    chk("irq masked", irq_o, 1'b0);
    chk("irq status", rdat, {30'h0, err, ser && !err});
    wb(1'b1, REG_IRQ_MASK, 32'h3);
    wb(1'b0, REG_IRQ_MASK, 32'h0);
    chk("irq raised", irq_o, ser);
    wb(1'b1, REG_IRQ_STAT, 32'h3);
    wb(1'b0, REG_IRQ_STAT, 32'h0);
    chk("irq cleared", irq_o, 1'b0);
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b0, REG_CTRL, 32'h0);
    chk("pll bypass", pll_bypass_o, a);
    for (k = 0; k < 16 && ser && !err; k++) begin
      wb(1'b0, MEM_BASE + 12'(4 * k), 32'h0);
      chk("image", rdat[7:0], k == 0 ? f : 8'(k) ^ 8'h3C);
    end
    $display("boot code %h finished", c);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Hang guard; a full run needs well under this
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 80000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    {rst_i, ce_i, power_on_reset_input_n_i, rel, alt, sck_q} = 6'b111000;
    {wb_cyc_i, wb_stb_i, wb_we_i, watchdog_config_strap_i} = 4'h0;
    {host_request_line_i, host_transmit_request_line_i} = 2'b00;
    {wb_adr_i, wb_sel_i, wb_dat_i, strap, id, first} = '0;
    wb_sel_i = 4'hF;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("bypass at reset", pll_bypass_o, 1'b1);
    wb(1'b1, 12'h200, 32'hFFFF_FFFF);
    wb(1'b0, 12'h200, 32'h0);
    chk("unmapped", rdat, 32'h0);
    $display("reset and bus test finished");
    run(4'h8, 8'h00, MAGIC_V, 1'b0, 1'b0, 1'b0, 1'b1);
    run(4'hB, 8'hC2, MAGIC_V, 1'b0, 1'b1, 1'b0, 1'b0);
    run(4'hC, 8'hFF, MAGIC_V, 1'b1, 1'b0, 1'b1, 1'b1);
    run(4'h9, 8'h20, 8'h3C, 1'b0, 1'b0, 1'b0, 1'b0);
    run(4'hC, 8'h00, 8'h11, 1'b1, 1'b1, 1'b0, 1'b1);
    run(4'h0, 8'h00, MAGIC_V, 1'b0, 1'b1, 1'b1, 1'b0);
    final_report();
  end
endmodule

bind smbl_loader smbl_asserts u_chk (
  .clk_i, .rst_i, .power_on_reset_input_n_i, .host_addr_line_three_o, .host_addr_line_three_oe_o,
  .host_chip_select_two_o, .host_chip_select_two_oe_o, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o,
  .event_output_three_o, .pll_bypass_o, .watchdog_cfg_o, .parallel_host_port_mode_o, .irq_o);
